// file: verilog/slb_latch_bank.sv
`timescale 1ns/1ns
`default_nettype none
module slb_latch_bank
  import slb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // serial link pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  // chip pins
  input wire logic chip_enable,
  input wire logic ref_in,
  input wire logic lock_in,
  // control latch fields
  output logic [1:0] prescaler_select,
  output logic [2:0] pump_current_one,
  output logic [2:0] pump_current_two,
  output logic [1:0] rf_output_level,
  output logic mute_until_lock,
  output logic pump_gain_select,
  output logic phase_detector_polarity,
  output logic [2:0] monitor_mux_select,
  output logic counter_reset_bit,
  output logic [1:0] core_bias_level,
  // feedback latch fields
  output logic halved_feedback_select,
  output logic output_halve,
  output logic [12:0] main_count,
  output logic [4:0] swallow_count,
  // reference latch fields
  output logic [1:0] band_clock_divider,
  output logic factory_test_bit,
  output logic lock_count_precision,
  output logic [1:0] antibacklash_width,
  output logic [13:0] ref_divider,
  // derived controls
  output logic [2:0] pump_current_active,
  output logic core_powered,
  output logic counters_load,
  output logic charge_pump_tristate,
  output logic lock_detect_reset,
  output logic rf_output_enable,
  output logic ref_buffer_enable,
  output logic band_select_active,
  output logic ref_div_pulse
);
  // pin synchronisers: 0 sclk, 1 sdata, 2 strobe, 3 ce, 4 ref, 5 lock
  logic [5:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [WORD_W-1:0] shift_q; // serial input register
  logic [WORD_W-1:0] ctrl_q, fb_q, rf_q; // the three latches
  logic gain_q; // shared pump gain flag
  slb_pwr_t pwr_q; // software power state
  logic [1:0] sync_cnt_q; // divider edges seen while waiting
  logic [13:0] rcnt_q; // reference counter
  logic [2:0] bclk_q; // band clock prescale
  logic [2:0] band_cnt_q; // band select cycles left
  logic fb_dirty_q; // feedback rewritten while down
  logic core_prev_q; // core power last cycle
  logic pulse_prev_q; // divider output last cycle
  logic div_edge; // divider output rising edge
  logic sclk_rise, strobe_rise, ref_rise, word_ctrl, word_fb, word_ref;
  logic bclk_tick, ce_ok, lock_ok;

  // three synchroniser stages
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
    end else begin
      s1_q <= {lock_in, ref_in, chip_enable, latch_strobe, ser_data, ser_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // filtered levels
  always_ff @(posedge mclk) begin
    if (reset) begin
      lvl_q <= 6'h00;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  assign sclk_rise = lvl_d[0] & ~lvl_q[0];
  assign strobe_rise = lvl_d[2] & ~lvl_q[2];
  assign ref_rise = lvl_d[4] & ~lvl_q[4];
  assign ce_ok = lvl_q[3];
  assign lock_ok = lvl_q[5];

  // shift in msb first, also while powered down
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_q <= 24'h000000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], lvl_d[1]};
    end
  end

  // decode of the latch select bits; code 11 is ignored
  assign word_ctrl = strobe_rise && (shift_q[1:0] == SEL_CTRL);
  assign word_fb = strobe_rise && (shift_q[1:0] == SEL_FB);
  assign word_ref = strobe_rise && (shift_q[1:0] == SEL_REF);

  // latch transfer on the strobe edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= 24'h000000;
      fb_q <= 24'h000000;
      rf_q <= 24'h000000;
    end else begin
      if (word_ctrl) begin
        ctrl_q <= shift_q;
      end
      if (word_fb) begin
        fb_q <= shift_q;
      end
      if (word_ref) begin
        rf_q <= shift_q;
      end
    end
  end

  // shared gain bit: whichever of the control and feedback latches wrote last
  always_ff @(posedge mclk) begin
    if (reset) begin
      gain_q <= 1'b0;
    end else if (word_ctrl) begin
      gain_q <= shift_q[C_GAIN];
    end else if (word_fb) begin
      gain_q <= shift_q[F_GAIN];
    end
  end

  // field outputs; spare bits have no output
  assign prescaler_select = ctrl_q[C_PRESC+:2];
  assign pump_current_two = ctrl_q[C_CUR2+:3];
  assign pump_current_one = ctrl_q[C_CUR1+:3];
  assign rf_output_level = ctrl_q[C_LEVEL+:2];
  assign mute_until_lock = ctrl_q[C_MUTE];
  assign pump_gain_select = gain_q;
  assign phase_detector_polarity = ctrl_q[C_POL];
  assign monitor_mux_select = ctrl_q[C_MUX+:3];
  assign counter_reset_bit = ctrl_q[C_CRST];
  assign core_bias_level = ctrl_q[C_BIAS+:2];
  assign halved_feedback_select = fb_q[F_HSEL];
  assign output_halve = fb_q[F_HALVE];
  assign main_count = fb_q[F_MAIN+:13];
  assign swallow_count = fb_q[F_SWAL+:5];
  assign band_clock_divider = rf_q[R_BCLK+:2];
  assign factory_test_bit = rf_q[R_TEST];
  assign lock_count_precision = rf_q[R_PREC];
  assign antibacklash_width = rf_q[R_ABL+:2];
  assign ref_divider = rf_q[R_DIV+:14];

  // gain picks the active current setting
  assign pump_current_active = gain_q ? ctrl_q[C_CUR2+:3] : ctrl_q[C_CUR1+:3];

  // software power state machine
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwr_q <= PW_OFF; // core off after supply
    end else if (word_ctrl) begin
      if (!shift_q[C_PD_REQ]) begin
        pwr_q <= PW_ON;
      end else if (!shift_q[C_PD_MODE]) begin
        pwr_q <= PW_DOWN;
      end else if (pwr_q == PW_DOWN) begin
        pwr_q <= PW_DOWN;
      end else begin
        pwr_q <= PW_WAIT;
      end
    end else if (pwr_q == PW_WAIT && div_edge && sync_cnt_q == SYNC_EDGES - 2'h1) begin
      pwr_q <= PW_DOWN;
    end
  end

  // divider output edges counted after the strobe
  always_ff @(posedge mclk) begin
    if (reset || word_ctrl) begin
      sync_cnt_q <= 2'h0;
    end else if (pwr_q == PW_WAIT && div_edge) begin
      sync_cnt_q <= sync_cnt_q + 2'h1;
    end
  end

  // chip enable overrides the programmed bits
  assign core_powered = ce_ok && (pwr_q == PW_ON || pwr_q == PW_WAIT);

  // power-down side effects
  assign counters_load = !core_powered || counter_reset_bit;
  assign charge_pump_tristate = !core_powered || ctrl_q[C_TRI];
  assign lock_detect_reset = !core_powered;
  assign ref_buffer_enable = core_powered;
  // mute until lock
  assign rf_output_enable = core_powered && !(mute_until_lock && !lock_ok);

  // reference counter, output pulse at terminal count
  always_ff @(posedge mclk) begin
    if (reset || counters_load) begin
      rcnt_q <= 14'h0001;
    end else if (ref_rise) begin
      rcnt_q <= (rcnt_q >= ref_divider) ? 14'h0001 : rcnt_q + 14'h0001;
    end
  end
  assign ref_div_pulse = !counters_load && (rcnt_q >= ref_divider);

  // output rising edge; a pulse already high at the strobe is not counted
  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= ref_div_pulse;
    end
  end
  // divide by one keeps the output high, so each reference edge counts then
  assign div_edge = ref_div_pulse
    && (!pulse_prev_q || (ref_rise && ref_divider <= 14'h0001));

  // band clock prescale by 1, 2, 4 or 8
  always_ff @(posedge mclk) begin
    if (reset || counters_load) begin
      bclk_q <= 3'h0;
    end else if (div_edge) begin
      bclk_q <= bclk_q + 3'h1;
    end
  end
  always_comb begin
    unique case (band_clock_divider)
      2'h0: bclk_tick = 1'b1;
      2'h1: bclk_tick = bclk_q[0];
      2'h2: bclk_tick = &bclk_q[1:0];
      2'h3: bclk_tick = &bclk_q;
    endcase
  end

  // feedback rewrite while down forces a fresh band search
  always_ff @(posedge mclk) begin
    if (reset) begin
      fb_dirty_q <= 1'b1;
      core_prev_q <= 1'b0;
    end else begin
      core_prev_q <= core_powered;
      if (word_fb && !core_powered) begin
        fb_dirty_q <= 1'b1;
      end else if (core_powered) begin
        fb_dirty_q <= 1'b0;
      end
    end
  end

  // band select: five band clock ticks, each 1, 2, 4 or 8 divider edges
  always_ff @(posedge mclk) begin
    if (reset || !core_powered) begin
      band_cnt_q <= 3'h0; // band itself is held
    end else if (word_fb || (!core_prev_q && fb_dirty_q)) begin
      band_cnt_q <= BAND_CYCLES;
    end else if (band_cnt_q != 3'h0 && div_edge && bclk_tick) begin
      band_cnt_q <= band_cnt_q - 3'h1;
    end
  end
  assign band_select_active = band_cnt_q != 3'h0; // tuning to reference

  // an asynchronous request lands the state one edge after the strobe
  a_async_down: assert property (@(posedge mclk) disable iff (reset)
    word_ctrl && shift_q[C_PD_REQ] && !shift_q[C_PD_MODE]
    |=> pwr_q == PW_DOWN && !core_powered)
    else $error("async power-down not taken");

  // the synchronous request waits for divider edges
  sequence s_sync_req;
    word_ctrl && shift_q[C_PD_REQ] && shift_q[C_PD_MODE] && pwr_q == PW_ON;
  endsequence
  a_sync_wait: assert property (@(posedge mclk) disable iff (reset)
    s_sync_req |=> pwr_q == PW_WAIT)
    else $error("sync power-down entered early");
  a_sync_edges: assert property (@(posedge mclk) disable iff (reset)
    pwr_q == PW_WAIT && $past(pwr_q) == PW_WAIT ##1 pwr_q == PW_DOWN
    |-> $past(sync_cnt_q, 2) == SYNC_EDGES - 2'h1)
    else $error("sync power-down edge count wrong");
  a_ce_off: assert property (@(posedge mclk) disable iff (reset)
    !ce_ok |-> !core_powered && counters_load && !rf_output_enable)
    else $error("chip enable low but core on");
  a_down_effects: assert property (@(posedge mclk) disable iff (reset)
    !core_powered |-> charge_pump_tristate && lock_detect_reset
    && !ref_buffer_enable && !ref_div_pulse)
    else $error("power-down effect missing");
  a_first_ctrl: assert property (@(posedge mclk) disable iff (reset)
    pwr_q == PW_OFF ##1 pwr_q != PW_OFF |-> $past(word_ctrl))
    else $error("core woke without control word");
  a_gain_last: assert property (@(posedge mclk) disable iff (reset)
    word_fb |=> pump_gain_select == $past(shift_q[F_GAIN]))
    else $error("gain bit not last written");
  a_gain_pick: assert property (@(posedge mclk) disable iff (reset)
    pump_gain_select |-> pump_current_active == ctrl_q[C_CUR2+:3])
    else $error("wrong current setting");
  a_mute_lock: assert property (@(posedge mclk) disable iff (reset)
    mute_until_lock && !lock_ok |-> !rf_output_enable)
    else $error("output on before lock");
  a_band_start: assert property (@(posedge mclk) disable iff (reset)
    word_fb && core_powered ##1 core_powered |-> band_cnt_q == BAND_CYCLES)
    else $error("band select not started");
  a_crst_hold: assert property (@(posedge mclk) disable iff (reset)
    counter_reset_bit ##1 counter_reset_bit |-> rcnt_q == 14'h0001)
    else $error("counter ran during reset");
  a_ref_latch: assert property (@(posedge mclk) disable iff (reset)
    word_ref |=> rf_q == $past(shift_q) && ctrl_q == $past(ctrl_q))
    else $error("reference word misrouted");
endmodule : slb_latch_bank
`default_nettype wire

// file: verilog/slb_pkg.sv
package slb_pkg;
  localparam int WORD_W = 24;
  // latch select codes in bits 1:0
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_REF = 2'h1;
  localparam logic [1:0] SEL_FB = 2'h2;
  // control latch fields
  localparam int C_PRESC = 22;
  localparam int C_PD_MODE = 21;
  localparam int C_PD_REQ = 20;
  localparam int C_CUR2 = 17;
  localparam int C_CUR1 = 14;
  localparam int C_LEVEL = 12;
  localparam int C_MUTE = 11;
  localparam int C_GAIN = 10;
  localparam int C_TRI = 9;
  localparam int C_POL = 8;
  localparam int C_MUX = 5;
  localparam int C_CRST = 4;
  localparam int C_BIAS = 2;
  // feedback latch fields
  localparam int F_HSEL = 23;
  localparam int F_HALVE = 22;
  localparam int F_GAIN = 21;
  localparam int F_MAIN = 8;
  localparam int F_SWAL = 2;
  // reference latch fields
  localparam int R_BCLK = 20;
  localparam int R_TEST = 19;
  localparam int R_PREC = 18;
  localparam int R_ABL = 16;
  localparam int R_DIV = 2;
  // timing counts
  localparam logic [2:0] BAND_CYCLES = 3'h5;
  localparam logic [1:0] SYNC_EDGES = 2'h2;
  // power states
  typedef enum logic [1:0] {PW_OFF, PW_ON, PW_WAIT, PW_DOWN} slb_pwr_t;
endpackage : slb_pkg

// file: bench/slb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module slb_host_model (
  // clock
  input wire logic mclk,
  // serial link pins
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // clock and strobe stand low outside frames; data keeps its last driven value
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // one word msb first, gap sets the pace (4 prompt, 8 slow)
  task automatic send(input logic [23:0] word, input int gap);
    for (int i = 23; i >= 0; i--) begin
      @(posedge mclk);
      ser_data <= word[i];
      repeat (gap) @(posedge mclk);
      ser_clk <= 1'b1;
      repeat (gap) @(posedge mclk);
      ser_clk <= 1'b0;
    end
    repeat (gap) @(posedge mclk);
    ser_data <= ~word[0]; // released data line shows no stale value
    latch_strobe <= 1'b1;
    repeat (gap) @(posedge mclk);
    latch_strobe <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask
endmodule // slb_host_model
`default_nettype wire

// file: bench/test_synth_latch_bank_power_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_synth_latch_bank_power_control
  import slb_pkg::*;
;
  // pins and observed outputs
  logic mclk, reset, ser_clk, ser_data, latch_strobe, chip_enable, ref_in, lock_in;
  logic [1:0] prescaler_select, rf_output_level, core_bias_level;
  logic [1:0] band_clock_divider, antibacklash_width;
  logic [2:0] pump_current_one, pump_current_two, monitor_mux_select, pump_current_active;
  logic mute_until_lock, pump_gain_select, phase_detector_polarity, counter_reset_bit;
  logic halved_feedback_select, output_halve, factory_test_bit, lock_count_precision;
  logic core_powered, counters_load, charge_pump_tristate, lock_detect_reset;
  logic rf_output_enable, ref_buffer_enable, band_select_active, ref_div_pulse;
  logic [12:0] main_count;
  logic [4:0] swallow_count;
  logic [13:0] ref_divider;
  // bookkeeping
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int pulses = 0;
  int n;
  logic [2:0] stb_d = 3'h0;
  logic pulse_q = 1'b0;
  // reference word: spare 11, band clock 2, test 1, precision 1, backlash 3, divide 3
  localparam logic [23:0] REF_W = {2'h3, 2'h2, 1'h1, 1'h1, 2'h3, 14'h0003, SEL_REF};
  localparam logic [23:0] FB_W = {1'h1, 1'h0, 1'h0, 13'h1ABC, 1'h1, 5'h15, SEL_FB};

  slb_latch_bank uut (.mclk, .reset, .ser_clk, .ser_data, .latch_strobe, .chip_enable,
    .ref_in, .lock_in, .prescaler_select, .pump_current_one, .pump_current_two,
    .rf_output_level, .mute_until_lock, .pump_gain_select, .phase_detector_polarity,
    .monitor_mux_select, .counter_reset_bit, .core_bias_level, .halved_feedback_select,
    .output_halve, .main_count, .swallow_count, .band_clock_divider, .factory_test_bit,
    .lock_count_precision, .antibacklash_width, .ref_divider, .pump_current_active,
    .core_powered, .counters_load, .charge_pump_tristate, .lock_detect_reset,
    .rf_output_enable, .ref_buffer_enable, .band_select_active, .ref_div_pulse);
  slb_host_model host (.mclk, .ser_clk, .ser_data, .latch_strobe);

  // control word with power-down bits {mode, request} and counter reset
  function automatic logic [23:0] ctl(input logic [1:0] pd, input logic crst);
    return {2'h2, pd, 3'h2, 3'h5, 2'h1, 1'h1, 1'h1, 1'h0, 1'h1, 3'h6, crst, 2'h3, SEL_CTRL};
  endfunction
  // compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // clock and reference input
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always begin
    repeat (10) @(posedge mclk);
    ref_in <= ~ref_in;
  end
  // divider pulse rises counted from the strobe as the device sees it
  always @(posedge mclk) begin
    stb_d <= {stb_d[1:0], latch_strobe};
    pulse_q <= ref_div_pulse;
    if (stb_d[2:1] == 2'b01) pulses <= 0;
    else if (ref_div_pulse === 1'b1 && pulse_q === 1'b0) pulses <= pulses + 1;
  end
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    reset = 1'b1;
    chip_enable = 1'b1;
    ref_in = 1'b0;
    lock_in = 1'b0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("core", 0, core_powered);
    chk("load", 1, counters_load);
    chk("tri", 1, charge_pump_tristate);
    // reference latch first
    host.send(REF_W, 4);
    chk("rdiv", 14'h0003, ref_divider);
    chk("bclk", 2, band_clock_divider);
    chk("test", 1, factory_test_bit);
    chk("prec", 1, lock_count_precision);
    chk("abl", 3, antibacklash_width);
    chk("core", 0, core_powered);
    // control latch at slow pace powers the core
    host.send(ctl(2'h0, 1'b0), 8);
    chk("ctl", 16'h12AF, {1'b0, prescaler_select, pump_current_two, pump_current_one,
      rf_output_level, mute_until_lock, pump_gain_select, phase_detector_polarity});
    chk("mux", 16'h0033, {monitor_mux_select, counter_reset_bit, core_bias_level});
    chk("core", 1, core_powered);
    chk("act", 2, pump_current_active);
    chk("tri", 0, charge_pump_tristate);
    chk("rfen", 0, rf_output_enable);
    lock_in <= 1'b1;
    repeat (50) @(posedge mclk);
    chk("rfen", 1, rf_output_enable);
    // feedback latch last starts band search
    host.send(FB_W, 4);
    chk("fb", 16'h1ABC, main_count);
    chk("fb2", 16'h0055, {halved_feedback_select, output_halve, swallow_count});
    chk("gain", 0, pump_gain_select);
    chk("act", 5, pump_current_active);
    for (n = 0; n < 200 && band_select_active !== 1'b1; n++) @(posedge mclk);
    chk("band", 1, band_select_active);
    for (n = 0; n < 3000 && band_select_active !== 1'b0; n++) @(posedge mclk);
    chk("band", 0, band_select_active);
    // select code 11 changes nothing
    host.send(24'hFFFFFF, 4);
    chk("fb", 16'h1ABC, main_count);
    chk("rdiv", 14'h0003, ref_divider);
    // counter reset holds the counters
    host.send(ctl(2'h0, 1'b1), 4);
    chk("gain", 1, pump_gain_select);
    repeat (150) @(posedge mclk);
    chk("load", 1, counters_load);
    chk("pulse", 0, pulses);
    host.send(ctl(2'h0, 1'b0), 4);
    chk("load", 0, counters_load);
    // immediate power-down, latches still written while down
    host.send(ctl(2'h1, 1'b0), 4);
    chk("down", 16'h001C, {core_powered, counters_load, charge_pump_tristate,
      lock_detect_reset, rf_output_enable, ref_buffer_enable});
    host.send({REF_W[23:18], 2'h1, REF_W[15:0]}, 4);
    chk("abl", 1, antibacklash_width);
    host.send(ctl(2'h0, 1'b0), 4);
    repeat (20) @(posedge mclk);
    chk("core", 1, core_powered);
    chk("band", 0, band_select_active);
    // chip enable low wins over the latch
    chip_enable <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("core", 0, core_powered);
    chk("rbuf", 0, ref_buffer_enable);
    chip_enable <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("core", 1, core_powered);
    chk("band", 0, band_select_active);
    // synchronous power-down on the second divider pulse
    host.send(ctl(2'h3, 1'b0), 4);
    chk("core", 1, core_powered);
    for (n = 0; n < 400 && core_powered !== 1'b0; n++) @(posedge mclk);
    @(posedge mclk);
    chk("core", 0, core_powered);
    chk("pulse", 2, pulses);
    complete_run();
  end
endmodule // test_synth_latch_bank_power_control
`default_nettype wire
